//--- inc/vpic_consts.vh
// constants for the vectored priority interrupt controller
`ifndef VPIC_CONSTS_VH
`define VPIC_CONSTS_VH
`define VPIC_BASE_HI 16'hFFFF
`define VPIC_OFS_WIDTH 16
`define OFS_NORMAL_ACTIVE 16'h0000
`define OFS_NORMAL_RAW 16'h0004
`define OFS_NORMAL_EN_SET 16'h0008
`define OFS_NORMAL_EN_CLR 16'h000C
`define OFS_SW_TRIGGER 16'h0010
`define OFS_VECTOR_BASE 16'h0014
`define OFS_NORMAL_VECTOR 16'h001C
`define OFS_PRIO_1_7 16'h0020
`define OFS_PRIO_8_15 16'h0024
`define OFS_PRIO_16_19 16'h0028
`define OFS_NESTING 16'h0030
`define OFS_EXT_TRIGGER 16'h0034
`define OFS_EXT_EDGE_CLR 16'h0038
`define OFS_NORMAL_SERVICED 16'h003C
`define OFS_FAST_ACTIVE 16'h0100
`define OFS_FAST_RAW 16'h0104
`define OFS_FAST_EN_SET 16'h0108
`define OFS_FAST_EN_CLR 16'h010C
`define OFS_FAST_VECTOR 16'h011C
`define OFS_FAST_SERVICED 16'h013C
`define RESET_WORD 32'h00000000
`define NEST_NORMAL_BIT 0
`define NEST_FAST_BIT 1
`define TRIG_RISING 2'h0
`define TRIG_FALLING 2'h1
`define PRIO_FIELD_W 4
`define PRIO_LEVELS 8
`define PRIO_LOWEST 3'h7
`define VEC_TABLE_LSB 6
`endif

//--- src/vectored_priority_interrupt_ctrl.v
// vectored prioritised interrupt controller with register port
`timescale 1ns/100ps
`include "vpic_consts.vh"
module vectored_priority_interrupt_ctrl #(
    parameter NUM_SRC = 20,
    parameter NUM_EXT = 4,
    parameter EXT_FIRST = 13
) (
    input wire sysClk,
    input wire sys_rst,
    input wire [31:0] regAddr,
    input wire regWrite,
    input wire regRead,
    input wire [31:0] regWdata,
    output reg [31:0] regRdata,
    output reg regRvalid,
    input wire [NUM_SRC-1:0] periphSrc,
    input wire [NUM_EXT-1:0] extPin,
    input wire irqAck,
    input wire fiqAck,
    output reg irqReq,
    output reg fiqReq
);
    // sysClk port name kept camelCase per house style
    reg [31:0] enNormal;
    reg [31:0] enFast;
    reg [31:0] swTrigger;
    reg [31:0] vecBase;
    reg [31:0] prio0;
    reg [31:0] prio1;
    reg [31:0] prio2;
    reg [31:0] nesting;
    reg [31:0] extTrig;
    reg [7:0] servNormal;
    reg [7:0] servFast;
    reg [NUM_EXT-1:0] extSync1;
    reg [NUM_EXT-1:0] extSync2;
    reg [NUM_EXT-1:0] extPrev;
    reg [NUM_EXT-1:0] extLatch;
    reg [31:0] vecNormal;
    reg [31:0] vecFast;
    reg [31:0] activeNormal;
    reg [31:0] activeFast;

    wire inBase = (regAddr[31:16] == `VPIC_BASE_HI);
    wire [15:0] ofs = regAddr[15:0];
    wire wrEn = regWrite & inBase;

    // external level after synchronisation, edge or level per source
    reg [NUM_EXT-1:0] extLevel;
    reg [NUM_EXT-1:0] extEdge;
    wire [NUM_EXT-1:0] extClr;
    genvar g;
    generate
        for (g = 0; g < NUM_EXT; g = g + 1) begin : extGen
            always @* begin
                extEdge[g] = (extTrig[2*g+1:2*g] == `TRIG_RISING) ? (extSync2[g] & ~extPrev[g]) :
                    (extTrig[2*g+1:2*g] == `TRIG_FALLING) ? (~extSync2[g] & extPrev[g]) : 1'b0;
                extLevel[g] = extTrig[2*g+1] ? extSync2[g] : extLatch[g];
            end
            assign extClr[g] = wrEn & (ofs == `OFS_EXT_EDGE_CLR) & regWdata[EXT_FIRST+g];
        end
    endgenerate

    // raw source picture, sources above NUM_SRC read zero
    reg [31:0] rawSrc;
    integer k;
    integer kPrio;
    integer kWinN;
    integer kWinF;
    integer kServ;
    always @* begin
        rawSrc = `RESET_WORD;
        for (k = 0; k < NUM_SRC; k = k + 1) begin
            rawSrc[k] = periphSrc[k] | swTrigger[k];
        end
        for (k = 0; k < NUM_EXT; k = k + 1) begin
            rawSrc[EXT_FIRST+k] = rawSrc[EXT_FIRST+k] | extLevel[k];
        end
    end

    // per-source priority; source 0 has no field and sits at level 0
    reg [2:0] prioOf [0:31];
    always @* begin
        for (kPrio = 0; kPrio < 32; kPrio = kPrio + 1) begin
            prioOf[kPrio] = `PRIO_LOWEST;
        end
        prioOf[0] = 3'h0;
        for (kPrio = 1; kPrio < 8; kPrio = kPrio + 1) begin
            prioOf[kPrio] = prio0[kPrio*`PRIO_FIELD_W +: 3];
        end
        for (kPrio = 0; kPrio < 8; kPrio = kPrio + 1) begin
            prioOf[8+kPrio] = prio1[kPrio*`PRIO_FIELD_W +: 3];
        end
        for (kPrio = 0; kPrio < 4; kPrio = kPrio + 1) begin
            prioOf[16+kPrio] = prio2[kPrio*`PRIO_FIELD_W +: 3];
        end
    end

    // active is raw gated by enable
    wire [31:0] nextActiveNormal = rawSrc & enNormal;
    wire [31:0] nextActiveFast = rawSrc & enFast;

    // lowest level number wins, scan upward
    reg [4:0] winNormal;
    reg [2:0] winNormalPrio;
    reg anyNormal;
    always @* begin
        winNormal = 5'h00;
        winNormalPrio = `PRIO_LOWEST;
        anyNormal = 1'b0;
        for (kWinN = 0; kWinN < 32; kWinN = kWinN + 1) begin
            // strict compare keeps the lower source number on a tie
            if (nextActiveNormal[kWinN] && (!anyNormal || prioOf[kWinN] < winNormalPrio)) begin
                winNormal = kWinN[4:0];
                winNormalPrio = prioOf[kWinN];
                anyNormal = 1'b1;
            end
        end
    end

    reg [4:0] winFast;
    reg [2:0] winFastPrio;
    reg anyFast;
    always @* begin
        winFast = 5'h00;
        winFastPrio = `PRIO_LOWEST;
        anyFast = 1'b0;
        for (kWinF = 0; kWinF < 32; kWinF = kWinF + 1) begin
            if (nextActiveFast[kWinF] && (!anyFast || prioOf[kWinF] < winFastPrio)) begin
                winFast = kWinF[4:0];
                winFastPrio = prioOf[kWinF];
                anyFast = 1'b1;
            end
        end
    end

    // nesting: only a level above all in service requests
    reg [3:0] topServNormal;
    reg [3:0] topServFast;
    always @* begin
        topServNormal = 4'h8;
        topServFast = 4'h8;
        for (kServ = `PRIO_LEVELS - 1; kServ >= 0; kServ = kServ - 1) begin
            if (servNormal[kServ]) begin
                topServNormal = kServ[3:0];
            end
            if (servFast[kServ]) begin
                topServFast = kServ[3:0];
            end
        end
    end
    wire next_irqReq = anyNormal &
        (~nesting[`NEST_NORMAL_BIT] | ({1'b0, winNormalPrio} < topServNormal));
    wire next_fiqReq = anyFast &
        (~nesting[`NEST_FAST_BIT] | ({1'b0, winFastPrio} < topServFast));

    // vector from table base, two bytes per entry
    wire [31:0] next_vecNormal = anyNormal ?
        {vecBase[31:`VEC_TABLE_LSB], winNormal, 1'b0} : `RESET_WORD;
    wire [31:0] next_vecFast = anyFast ?
        {vecBase[31:`VEC_TABLE_LSB], winFast, 1'b0} : `RESET_WORD;

    // one-hot level of the interrupt just taken
    wire [7:0] takeNormal = irqAck ? (8'h01 << winNormalPrio) : 8'h00;
    wire [7:0] takeFast = fiqAck ? (8'h01 << winFastPrio) : 8'h00;

    // pins pass two flops before any logic
    always @(posedge sysClk or posedge sys_rst) begin
        if (sys_rst) begin
            extSync1 <= {NUM_EXT{1'b0}};
            extSync2 <= {NUM_EXT{1'b0}};
            extPrev <= {NUM_EXT{1'b0}};
            extLatch <= {NUM_EXT{1'b0}};
        end else begin
            extSync1 <= extPin;
            extSync2 <= extSync1;
            extPrev <= extSync2;
            // new edge wins over a clear
            extLatch <= (extLatch & ~extClr) | extEdge;
        end
    end

    // status, vectors and requests trail the sources by one edge
    always @(posedge sysClk or posedge sys_rst) begin
        if (sys_rst) begin
            activeNormal <= `RESET_WORD;
            activeFast <= `RESET_WORD;
            vecNormal <= `RESET_WORD;
            vecFast <= `RESET_WORD;
            irqReq <= 1'b0;
            fiqReq <= 1'b0;
        end else begin
            activeNormal <= nextActiveNormal;
            activeFast <= nextActiveFast;
            vecNormal <= next_vecNormal;
            vecFast <= next_vecFast;
            irqReq <= next_irqReq;
            fiqReq <= next_fiqReq;
        end
    end

    // set by enable write, clear by disable write
    always @(posedge sysClk or posedge sys_rst) begin
        if (sys_rst) begin
            enNormal <= `RESET_WORD;
        end else if (wrEn && ofs == `OFS_NORMAL_EN_SET) begin
            enNormal <= enNormal | regWdata;
        end else if (wrEn && ofs == `OFS_NORMAL_EN_CLR) begin
            enNormal <= enNormal & ~regWdata;
        end
    end

    always @(posedge sysClk or posedge sys_rst) begin
        if (sys_rst) begin
            enFast <= `RESET_WORD;
        end else if (wrEn && ofs == `OFS_FAST_EN_SET) begin
            enFast <= enFast | regWdata;
        end else if (wrEn && ofs == `OFS_FAST_EN_CLR) begin
            enFast <= enFast & ~regWdata;
        end
    end

    always @(posedge sysClk or posedge sys_rst) begin
        if (sys_rst) begin
            swTrigger <= `RESET_WORD;
        end else if (wrEn && ofs == `OFS_SW_TRIGGER) begin
            swTrigger <= regWdata;
        end
    end

    always @(posedge sysClk or posedge sys_rst) begin
        if (sys_rst) begin
            vecBase <= `RESET_WORD;
        end else if (wrEn && ofs == `OFS_VECTOR_BASE) begin
            vecBase <= regWdata;
        end
    end

    always @(posedge sysClk or posedge sys_rst) begin
        if (sys_rst) begin
            prio0 <= `RESET_WORD;
        end else if (wrEn && ofs == `OFS_PRIO_1_7) begin
            prio0 <= regWdata;
        end
    end

    always @(posedge sysClk or posedge sys_rst) begin
        if (sys_rst) begin
            prio1 <= `RESET_WORD;
        end else if (wrEn && ofs == `OFS_PRIO_8_15) begin
            prio1 <= regWdata;
        end
    end

    always @(posedge sysClk or posedge sys_rst) begin
        if (sys_rst) begin
            prio2 <= `RESET_WORD;
        end else if (wrEn && ofs == `OFS_PRIO_16_19) begin
            prio2 <= regWdata;
        end
    end

    always @(posedge sysClk or posedge sys_rst) begin
        if (sys_rst) begin
            nesting <= `RESET_WORD;
        end else if (wrEn && ofs == `OFS_NESTING) begin
            nesting <= regWdata;
        end
    end

    always @(posedge sysClk or posedge sys_rst) begin
        if (sys_rst) begin
            extTrig <= `RESET_WORD;
        end else if (wrEn && ofs == `OFS_EXT_TRIGGER) begin
            extTrig <= regWdata;
        end
    end

    // taken level set wins over software clear
    always @(posedge sysClk or posedge sys_rst) begin
        if (sys_rst) begin
            servNormal <= 8'h00;
        end else if (wrEn && ofs == `OFS_NORMAL_SERVICED) begin
            servNormal <= (servNormal & ~regWdata[7:0]) | takeNormal;
        end else begin
            servNormal <= servNormal | takeNormal;
        end
    end

    always @(posedge sysClk or posedge sys_rst) begin
        if (sys_rst) begin
            servFast <= 8'h00;
        end else if (wrEn && ofs == `OFS_FAST_SERVICED) begin
            servFast <= (servFast & ~regWdata[7:0]) | takeFast;
        end else begin
            servFast <= servFast | takeFast;
        end
    end

    // read decode within base window; unmapped reads zero
    reg [31:0] next_regRdata;
    always @* begin
        next_regRdata = `RESET_WORD;
        if (inBase) begin
            case (ofs)
                `OFS_NORMAL_ACTIVE: next_regRdata = activeNormal;
                `OFS_NORMAL_RAW: next_regRdata = rawSrc;
                `OFS_NORMAL_EN_SET: next_regRdata = enNormal;
                `OFS_VECTOR_BASE: next_regRdata = vecBase;
                `OFS_NORMAL_VECTOR: next_regRdata = vecNormal;
                `OFS_PRIO_1_7: next_regRdata = prio0;
                `OFS_PRIO_8_15: next_regRdata = prio1;
                `OFS_PRIO_16_19: next_regRdata = prio2;
                `OFS_NESTING: next_regRdata = nesting;
                `OFS_EXT_TRIGGER: next_regRdata = extTrig;
                `OFS_NORMAL_SERVICED: next_regRdata = {24'h000000, servNormal};
                `OFS_FAST_ACTIVE: next_regRdata = activeFast;
                `OFS_FAST_RAW: next_regRdata = rawSrc;
                `OFS_FAST_EN_SET: next_regRdata = enFast;
                `OFS_FAST_VECTOR: next_regRdata = vecFast;
                `OFS_FAST_SERVICED: next_regRdata = {24'h000000, servFast};
                // write-only locations read zero
                `OFS_NORMAL_EN_CLR: next_regRdata = `RESET_WORD;
                `OFS_SW_TRIGGER: next_regRdata = `RESET_WORD;
                `OFS_EXT_EDGE_CLR: next_regRdata = `RESET_WORD;
                `OFS_FAST_EN_CLR: next_regRdata = `RESET_WORD;
                default: next_regRdata = `RESET_WORD;
            endcase
        end
    end

    // read data holds between reads so a slow master can still take it
    always @(posedge sysClk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdata <= `RESET_WORD;
        end else if (regRead) begin
            regRdata <= next_regRdata;
        end
    end

    always @(posedge sysClk or posedge sys_rst) begin
        if (sys_rst) begin
            regRvalid <= 1'b0;
        end else begin
            regRvalid <= regRead;
        end
    end
endmodule

//--- tb/vpic_properties.sv
// port checker for the interrupt controller
`timescale 1ns/100ps
module vpic_props #(
    parameter NUM_SRC = 20
) (
    input wire sysClk,
    input wire sys_rst,
    input wire [31:0] regAddr,
    input wire regWrite,
    input wire regRead,
    input wire [31:0] regWdata,
    input wire [31:0] regRdata,
    input wire regRvalid,
    input wire [NUM_SRC-1:0] periphSrc,
    input wire irqAck,
    input wire irqReq,
    input wire fiqReq
);
    default clocking @(posedge sysClk); endclocking
    default disable iff (sys_rst);
    rvalid_pulse_a: assert property (regRead |=> regRvalid) // read answer
        else $error("read not answered");
    rvalid_cause_a: assert property (regRvalid |-> $past(regRead)) // read answer
        else $error("answer without read");
    rdata_hold_a: assert property (!regRvalid |-> $stable(regRdata)) // data held
        else $error("read data moved");
    unmapped_zero_a: assert property (regRead && regAddr[31:16] != 16'hFFFF
        |=> regRdata == 32'h0) // outside window
        else $error("outside read not zero");
    wo_read_zero_a: assert property (regRead && (regAddr == 32'hFFFF000C ||
        regAddr == 32'hFFFF010C) |=> regRdata == 32'h0) // disable regs
        else $error("disable reg read not zero");
    irq_disable_a: assert property (regWrite && regAddr == 32'hFFFF000C &&
        regWdata == 32'hFFFFFFFF |-> ##2 !irqReq) // all disabled
        else $error("irq after disable");
    fiq_disable_a: assert property (regWrite && regAddr == 32'hFFFF010C &&
        regWdata == 32'hFFFFFFFF |-> ##2 !fiqReq) // all disabled
        else $error("fiq after disable");
    raw_unused_a: assert property (regRead && regAddr == 32'hFFFF0004
        |=> regRdata[31:20] == 12'h000) // unused bits
        else $error("raw unused bits set");
    // ext sources 13..16 masked: their raw path is synchronised
    raw_reflect_a: assert property (regRead && regAddr == 32'hFFFF0004 &&
        periphSrc == $past(periphSrc) |=> (regRdata[19:0] & $past(periphSrc) &
        20'hE1FFF) == ($past(periphSrc) & 20'hE1FFF)) // raw view
        else $error("raw misses a source");
    cover property (irqAck && irqReq);
    cover property ($rose(fiqReq));
    cover property (regRead && regAddr == 32'hFFFF011C);
endmodule
bind vectored_priority_interrupt_ctrl vpic_props #(.NUM_SRC(NUM_SRC)) props (
    .sysClk(sysClk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid), .periphSrc(periphSrc), .irqAck(irqAck),
    .irqReq(irqReq), .fiqReq(fiqReq));

//--- tb/exception_ack_model.sv
// core model taking one request line
`timescale 1ns/100ps
module exception_ack_model (
    input wire sysClk,
    input wire sys_rst,
    input wire ackEnable,
    input wire [3:0] ackDelay,
    input wire req,
    output reg ack
);
    reg [3:0] waitCnt;
    reg taken;
    // one entry per request, after a chosen wait
    always @(posedge sysClk or posedge sys_rst) begin
        if (sys_rst) begin
            ack <= 1'b0;
            waitCnt <= 4'h0;
            taken <= 1'b0;
        end else begin
            ack <= 1'b0;
            if (!req) begin
                waitCnt <= 4'h0;
                taken <= 1'b0;
            end else if (ackEnable && !taken) begin
                waitCnt <= waitCnt + 4'h1;
                if (waitCnt == ackDelay) begin
                    ack <= 1'b1;
                    taken <= 1'b1;
                end
            end
        end
    end
endmodule

//--- tb/vectored_priority_interrupt_ctrl_test.sv
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
module vectored_priority_interrupt_ctrl_test;
    reg sysClk = 1'b0;
    reg sys_rst = 1'b1;
    reg [31:0] regAddr = 32'h0;
    reg regWrite = 1'b0;
    reg regRead = 1'b0;
    reg [31:0] regWdata = 32'h0;
    reg [19:0] periphSrc = 20'h0;
    reg [3:0] extPin = 4'h0;
    reg ackEn = 1'b0;
    wire [31:0] regRdata;
    wire regRvalid, irqReq, fiqReq, irqAck, fiqAck;
    integer n_fail = 0;
    integer total_checks = 0;
    integer cycles = 0;
    integer i;
    reg [95:0] rowTab [0:15];
    vectored_priority_interrupt_ctrl dut (.sysClk(sysClk), .sys_rst(sys_rst),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
        .periphSrc(periphSrc), .extPin(extPin), .irqAck(irqAck),
        .fiqAck(fiqAck), .irqReq(irqReq), .fiqReq(fiqReq));
    // prompt core on the normal line, slow on the fast one
    exception_ack_model irqCore (.sysClk(sysClk), .sys_rst(sys_rst),
        .ackEnable(ackEn), .ackDelay(4'h0), .req(irqReq), .ack(irqAck));
    exception_ack_model fiqCore (.sysClk(sysClk), .sys_rst(sys_rst),
        .ackEnable(ackEn), .ackDelay(4'h5), .req(fiqReq), .ack(fiqAck));
    task test_done;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task ticks(input integer n);
        begin
            repeat (n) @(posedge sysClk);
            #1;
        end
    endtask
    task wra(input [31:0] a, input [31:0] d);
        begin
            @(posedge sysClk);
            #1 regWrite = 1'b1;
            regAddr = a;
            regWdata = d;
            @(posedge sysClk);
            #1 regWrite = 1'b0;
        end
    endtask
    task wr(input [15:0] off, input [31:0] d);
        wra({16'hFFFF, off}, d);
    endtask
    // read data stands one cycle after the read edge
    task rda(input [31:0] a, input [31:0] exp);
        begin
            @(posedge sysClk);
            #1 regRead = 1'b1;
            regAddr = a;
            @(posedge sysClk);
            #1 regRead = 1'b0;
            chk("rvalid", {31'h0, regRvalid}, 32'h1); // answer pulse
            chk("rdata", regRdata, exp); // decoded data
        end
    endtask
    task rd(input [15:0] off, input [31:0] exp);
        rda({16'hFFFF, off}, exp);
    endtask
    initial begin
        forever #20 sysClk = ~sysClk;
    end
    always @(posedge sysClk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_fail = n_fail + 1;
            test_done;
        end
    end
    initial begin
        rowTab[0] = 96'h0008_FFFFFFFF_0008_FFFFFFFF;
        rowTab[1] = 96'h000C_FFFFFFFF_0008_00000000;
        rowTab[2] = 96'h0108_FFFFFFFF_0108_FFFFFFFF;
        rowTab[3] = 96'h010C_FFFFFFFF_0108_00000000;
        rowTab[4] = 96'h0014_12345640_0014_12345640;
        rowTab[5] = 96'h0020_FFFFFFFF_0020_FFFFFFFF;
        rowTab[6] = 96'h0024_FFFFFFFF_0024_FFFFFFFF;
        rowTab[7] = 96'h0028_FFFFFFFF_0028_FFFFFFFF;
        rowTab[8] = 96'h0030_FFFFFFFF_0030_FFFFFFFF;
        rowTab[9] = 96'h0034_000000FF_0034_000000FF;
        rowTab[10] = 96'h010C_00000000_010C_00000000;
        rowTab[11] = 96'h0038_FFFFFFFF_0038_00000000;
        rowTab[12] = 96'h0020_00205000_0020_00205000;
        rowTab[13] = 96'h0024_00000000_0024_00000000;
        rowTab[14] = 96'h0028_00000000_0030_FFFFFFFF;
        rowTab[15] = 96'h0030_00000000_0034_000000FF;
        repeat (20) @(posedge sysClk);
        #1 sys_rst = 1'b0;
        for (i = 0; i < 32; i = i + 1)
            rda({16'hFFFF, 7'h00, i[4], 2'h0, i[3:0], 2'h0}, 32'h0); // zero
        for (i = 0; i < 16; i = i + 1) begin
            wr(rowTab[i][95:80], rowTab[i][79:48]);
            chk("wrQuiet", {31'h0, regRvalid}, 32'h0); // no write answer
            rd(rowTab[i][47:32], rowTab[i][31:0]);
        end
        wr(16'h0034, 32'h0);
        wr(16'h0008, 32'h00000028);
        periphSrc = 20'h00028;
        ticks(3);
        chk("irqReq", {31'h0, irqReq}, 32'h1); // request level
        rd(16'h0000, 32'h00000028); // active sources
        rd(16'h001C, 32'h1234564A); // higher priority
        wr(16'h0020, 32'h00505000);
        rd(16'h001C, 32'h12345646); // tie to lower source
        ackEn = 1'b1;
        ticks(8);
        ackEn = 1'b0;
        rd(16'h003C, 32'h00000020); // serviced level
        wr(16'h0030, 32'h00000001);
        ticks(2);
        chk("irqNest", {31'h0, irqReq}, 32'h0); // equal level held
        wr(16'h0020, 32'h00105000);
        ticks(2);
        chk("irqPreempt", {31'h0, irqReq}, 32'h1); // higher level passes
        wr(16'h003C, 32'h00000020);
        rd(16'h003C, 32'h0); // cleared by one
        wr(16'h0030, 32'h0);
        periphSrc = 20'h000A8;
        wr(16'h0108, 32'h00000080);
        ticks(2);
        chk("fiqReq", {31'h0, fiqReq}, 32'h1); // fast request
        rd(16'h0100, 32'h00000080); // fast active
        rd(16'h011C, 32'h1234564E); // fast vector
        rd(16'h0104, 32'h000000A8); // fast raw
        ackEn = 1'b1;
        ticks(10);
        ackEn = 1'b0;
        rd(16'h013C, 32'h00000001); // fast serviced level
        rd(16'h003C, 32'h00000002); // normal serviced level
        wr(16'h000C, 32'hFFFFFFFF);
        wr(16'h010C, 32'hFFFFFFFF);
        ticks(1);
        chk("allOff", {30'h0, irqReq, fiqReq}, 32'h0); // nothing enabled
        periphSrc = 20'h0;
        wr(16'h0008, 32'h00000200);
        wr(16'h0010, 32'h00000200);
        ticks(2);
        chk("swReq", {31'h0, irqReq}, 32'h1); // software raised
        rd(16'h0004, 32'h00000200); // raw shows it
        wr(16'h0010, 32'h0);
        wr(16'h0008, 32'h00002000);
        extPin = 4'h1;
        ticks(6);
        extPin = 4'h0;
        ticks(6);
        rd(16'h0000, 32'h00002000); // rising edge latched
        wr(16'h0038, 32'h00002000);
        rd(16'h0000, 32'h0); // latch cleared
        wr(16'h0034, 32'h00000002);
        extPin = 4'h1;
        ticks(6);
        rd(16'h0000, 32'h00002000); // level high
        extPin = 4'h0;
        ticks(6);
        rd(16'h0000, 32'h0); // level gone
        wr(16'h0034, 32'h00000001);
        extPin = 4'h1;
        ticks(6);
        rd(16'h0000, 32'h0); // rise ignored
        extPin = 4'h0;
        ticks(6);
        rd(16'h0000, 32'h00002000); // falling edge latched
        wra(32'hFFFE0008, 32'hFFFFFFFF);
        rd(16'h0008, 32'h00002200); // outside write ignored
        rda(32'hFFFE0008, 32'h0); // outside read zero
        sys_rst = 1'b1;
        ticks(2);
        sys_rst = 1'b0;
        rd(16'h0008, 32'h0); // reset clears enables
        test_done;
    end
endmodule
